// ===== src/cpt_pkg.sv
/*
 * Constants for the cascadable timer block: register indices, control bit
 * positions, reset values and the tick divider.
 * Assumes a 100 MHz system clock that stands for the crystal clock.
 */
// Function
// RL1: First pair independent or cascaded PWM
// RL2: Second pair always cascaded 16-bit
// RL3: Each timer has reload and count registers
// RL4: Decrement to zero, request, optional reload
// RL5: Single-shot stops at zero, enable cleared
// RL6: Reload enabled keeps counting from reload
// RL7: Count write while running continues from it
// RL8: Reload write used at next reload
// RL9: Software count write beats decrement; clear beats write
// RL10: Reads never disturb timers
// RL11: Cascade requests only at 16-bit zero, even
// RL12: Even timer holds low byte
// RL13: Cascade always reloads and runs free
// RL14: Repeated zero before service not detected
// RL15: Control write starts enabled timers, no reload
// RL16: Tick once every eighth crystal clock
// RL17: PWM alternates low and high reload pairs
// RL18: PWM low first, odd request then even
// RL19: Software preloads counts with high-phase value
// RL20: Software sets pin direction and special function
// RL21: Timer zero request toggles output pin
// RL22: Reset leaves all timers disabled
// RL23: Control holds enables, reload, cascade, PWM
package cpt_pkg;
	// ----------------------------------------
	// Register indices
	// ----------------------------------------
	localparam logic [7:0] ADDR_COUNT0 = 8'h00;
	localparam logic [7:0] ADDR_COUNT1 = 8'h01;
	localparam logic [7:0] ADDR_COUNT2 = 8'h02;
	localparam logic [7:0] ADDR_COUNT3 = 8'h03;
	localparam logic [7:0] ADDR_LORL0 = 8'h04;
	localparam logic [7:0] ADDR_LORL1 = 8'h05;
	localparam logic [7:0] ADDR_LORL2 = 8'h06;
	localparam logic [7:0] ADDR_LORL3 = 8'h07;
	localparam logic [7:0] ADDR_HIRL0 = 8'h08;
	localparam logic [7:0] ADDR_HIRL1 = 8'h09;
	localparam logic [7:0] ADDR_CTRL = 8'h0A;
	localparam logic [7:0] ADDR_REQ = 8'h0B;
	localparam logic [7:0] ADDR_PORT_B_DIRECTION = 8'hD6;
	localparam logic [7:0] ADDR_PORT_B_SPECIAL_FUNCTION = 8'hD7;
	// ----------------------------------------
	// Control bit positions
	// ----------------------------------------
	localparam int CTRL_EN0 = 0;
	localparam int CTRL_EN1 = 1;
	localparam int CTRL_EN23 = 2;
	localparam int CTRL_RL0 = 4;
	localparam int CTRL_RL1 = 5;
	localparam int CTRL_CASC = 6;
	localparam int CTRL_PWM = 7;
	localparam int PIN_BIT = 1;
	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam int XTAL_PER_TICK = 8;
	localparam logic [2:0] TICK_LAST = 3'(XTAL_PER_TICK - 1);
endpackage : cpt_pkg

// ===== src/cpt_tick.sv
/*
 * Tick divider: one-cycle enable pulse every eighth clock.
 * Assumes the system clock is the crystal clock.
 */
`timescale 1ns/10ps
module cpt_tick (
	input wire logic clock_i,
	input wire logic nrst_i,
	output logic tick_o
);
	logic [2:0] cnt;

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			cnt <= 3'h0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= (cnt == cpt_pkg::TICK_LAST); // RL16
			cnt <= (cnt == cpt_pkg::TICK_LAST) ? 3'h0 : cnt + 3'h1;
		end
	end
endmodule : cpt_tick

// ===== src/cpt_timers.sv
/*
 * Four 8-bit down counters: pair 0/1 independent or cascaded (PWM capable),
 * pair 2/3 always cascaded, plus the toggle output and its port bits.
 * Assumes a single-cycle register port with read data one cycle later.
 */
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module cpt_timers (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	output logic [3:0] req_o,
	output logic timer_out_pin_o,
	output logic timer_out_pin_oe_o
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] count [4];
	logic [7:0] lo_rl [4];
	logic [7:0] hi_rl [2];
	logic [7:0] ctrl;
	logic [7:0] port_b_direction;
	logic [7:0] port_b_special_function;
	logic [3:0] req;
	logic pwm_high;
	logic timer_toggle_output;
	logic tick;
	logic [7:0] next_count [4];
	logic [3:0] next_req;
	logic next_pwm_high;
	logic clr_en0;
	logic clr_en1;
	logic wr_ctrl;

	cpt_tick u_tick (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.tick_o(tick)
	);

	function automatic logic wr_at(input logic w, input logic [7:0] a, input logic [7:0] r);
		wr_at = w && (a == r);
	endfunction : wr_at

	// ----------------------------------------
	// Counting
	// ----------------------------------------
	logic casc;
	logic pwm;
	logic [15:0] c01;
	logic [15:0] c23;
	assign casc = ctrl[cpt_pkg::CTRL_CASC];
	assign pwm = ctrl[cpt_pkg::CTRL_PWM] && casc;
	assign c01 = {count[1], count[0]}; // RL12
	assign c23 = {count[3], count[2]}; // RL12
	assign wr_ctrl = wr_at(wr_i, addr_i, cpt_pkg::ADDR_CTRL);

	always_comb begin
		next_count = count;
		next_req = 4'h0;
		next_pwm_high = pwm_high;
		clr_en0 = 1'b0;
		clr_en1 = 1'b0;
		if (tick) begin
			if (casc) begin // RL1
				if (ctrl[cpt_pkg::CTRL_EN0]) begin
					if (c01 == 16'h0000) begin
						// RL17
						if (pwm && pwm_high) begin
							{next_count[1], next_count[0]} = {hi_rl[1], hi_rl[0]};
							next_req[0] = 1'b1; // RL18
							next_pwm_high = 1'b0;
						end else begin
							{next_count[1], next_count[0]} = {lo_rl[1], lo_rl[0]}; // RL13
							next_req[1] = pwm; // RL18
							next_req[0] = !pwm; // RL11
							next_pwm_high = pwm;
						end
					end else begin
						{next_count[1], next_count[0]} = c01 - 16'h0001;
					end
				end
			end else begin
				for (int i = 0; i < 2; i++) begin
					if (ctrl[i]) begin
						if (count[i] == 8'h00) begin
							next_req[i] = 1'b1; // RL4
							if (ctrl[cpt_pkg::CTRL_RL0 + i]) begin
								next_count[i] = lo_rl[i]; // RL6
							end else if (i == 0) begin
								clr_en0 = 1'b1; // RL5
							end else begin
								clr_en1 = 1'b1; // RL5
							end
						end else begin
							next_count[i] = count[i] - 8'h01; // RL4
						end
					end
				end
			end
			if (ctrl[cpt_pkg::CTRL_EN23]) begin // RL2
				if (c23 == 16'h0000) begin
					{next_count[3], next_count[2]} = {lo_rl[3], lo_rl[2]}; // RL13
					next_req[2] = 1'b1; // RL11
				end else begin
					{next_count[3], next_count[2]} = c23 - 16'h0001;
				end
			end
		end
	end

	// Software write lands after hardware so it wins
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < 4; i++) begin
				count[i] <= cpt_pkg::BYTE_RESET;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (wr_at(wr_i, addr_i, cpt_pkg::ADDR_COUNT0 + 8'(i))) begin
					count[i] <= wdata_i; // RL9 RL7
				end else begin
					count[i] <= next_count[i];
				end
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < 4; i++) begin
				lo_rl[i] <= cpt_pkg::BYTE_RESET;
			end
			hi_rl[0] <= cpt_pkg::BYTE_RESET;
			hi_rl[1] <= cpt_pkg::BYTE_RESET;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (wr_at(wr_i, addr_i, cpt_pkg::ADDR_LORL0 + 8'(i))) begin
					lo_rl[i] <= wdata_i; // RL8 RL3
				end
			end
			for (int i = 0; i < 2; i++) begin
				if (wr_at(wr_i, addr_i, cpt_pkg::ADDR_HIRL0 + 8'(i))) begin
					hi_rl[i] <= wdata_i; // RL8
				end
			end
		end
	end

	// Control write just sets bits; counting resumes from count, no reload
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			ctrl <= cpt_pkg::CTRL_RESET; // RL22
		end else begin
			if (wr_ctrl) begin
				ctrl <= wdata_i; // RL15 RL23
			end
			if (clr_en0) begin
				ctrl[cpt_pkg::CTRL_EN0] <= 1'b0; // RL9
			end
			if (clr_en1) begin
				ctrl[cpt_pkg::CTRL_EN1] <= 1'b0; // RL9
			end
		end
	end

	// PWM always restarts in the low phase when mode is (re)written
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			pwm_high <= 1'b0;
		end else if (wr_ctrl) begin
			pwm_high <= 1'b0; // RL18
		end else begin
			pwm_high <= next_pwm_high;
		end
	end

	// Requests are sticky; a new event wins over the clear
	// A second zero before service merges into the pending bit
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			req <= 4'h0;
		end else if (wr_at(wr_i, addr_i, cpt_pkg::ADDR_REQ)) begin
			req <= (req & ~wdata_i[3:0]) | next_req; // RL14
		end else begin
			req <= req | next_req;
		end
	end

	// ----------------------------------------
	// Toggle output and port bits
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			timer_toggle_output <= 1'b0;
		end else if (next_req[0]) begin
			timer_toggle_output <= !timer_toggle_output; // RL21
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			port_b_direction <= 8'h00;
			port_b_special_function <= 8'h00;
		end else begin
			if (wr_at(wr_i, addr_i, cpt_pkg::ADDR_PORT_B_DIRECTION)) begin
				port_b_direction <= wdata_i; // RL20
			end
			if (wr_at(wr_i, addr_i, cpt_pkg::ADDR_PORT_B_SPECIAL_FUNCTION)) begin
				port_b_special_function <= wdata_i; // RL20
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			timer_out_pin_o <= 1'b0;
			timer_out_pin_oe_o <= 1'b0;
			req_o <= 4'h0;
		end else begin
			// One cycle behind the toggle flop; harmless for a pin
			timer_out_pin_o <= timer_toggle_output &
				port_b_special_function[cpt_pkg::PIN_BIT];
			timer_out_pin_oe_o <= port_b_direction[cpt_pkg::PIN_BIT];
			req_o <= req;
		end
	end

	// ----------------------------------------
	// Read port, side-effect free
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			unique case (addr_i) // RL10
				cpt_pkg::ADDR_COUNT0: rdata_o <= count[0];
				cpt_pkg::ADDR_COUNT1: rdata_o <= count[1];
				cpt_pkg::ADDR_COUNT2: rdata_o <= count[2];
				cpt_pkg::ADDR_COUNT3: rdata_o <= count[3];
				cpt_pkg::ADDR_LORL0: rdata_o <= lo_rl[0];
				cpt_pkg::ADDR_LORL1: rdata_o <= lo_rl[1];
				cpt_pkg::ADDR_LORL2: rdata_o <= lo_rl[2];
				cpt_pkg::ADDR_LORL3: rdata_o <= lo_rl[3];
				cpt_pkg::ADDR_HIRL0: rdata_o <= hi_rl[0];
				cpt_pkg::ADDR_HIRL1: rdata_o <= hi_rl[1];
				cpt_pkg::ADDR_CTRL: rdata_o <= ctrl;
				cpt_pkg::ADDR_REQ: rdata_o <= {4'h0, req};
				cpt_pkg::ADDR_PORT_B_DIRECTION: rdata_o <= port_b_direction;
				cpt_pkg::ADDR_PORT_B_SPECIAL_FUNCTION: rdata_o <= port_b_special_function;
				default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end
endmodule : cpt_timers

// ===== verif/cascadable_timers_with_pwm_tb.sv
/*
 * Self-checking bench for cpt_timers over its register port.
 * Assumes a tick every eighth clock and read data one cycle after the strobe.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module cascadable_timers_with_pwm_tb;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic [3:0] req_o;
	logic pin_o;
	logic pin_oe_o;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	realtime tlast;
	realtime t;
	always #5 clock_i = ~clock_i;
	cpt_timers dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .req_o(req_o),
		.timer_out_pin_o(pin_o), .timer_out_pin_oe_o(pin_oe_o));
	// ----------------------------------------
	// Bus and timing tasks
	// ----------------------------------------
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		`CHK("rdata", e, rdata_o)
	endtask : rd
	// Bounded so a dead timer fails the req check and the run goes on instead of hanging
	task waitreq(input int b);
		int n;
		n = 0;
		do begin
			@(posedge clock_i);
			#1;
			n++;
		end while (req_o[b] !== 1'b1 && n < 4000);
		`CHK("req", 1'b1, req_o[b])
		tlast = $realtime;
	endtask : waitreq
	task gap(input int c, input int w, input int e);
		t = tlast;
		wr(cpt_pkg::ADDR_REQ, 8'(1 << c));
		waitreq(w);
		`CHK("period", e, int'((tlast - t) / 10.0))
	endtask : gap
	task report_and_stop;
		$display("Checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			report_and_stop();
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clock_i);
		nrst_i <= 1'b1;
		rd(cpt_pkg::ADDR_CTRL, 8'h00);
		rd(8'hC0, 8'h00);
		wr(cpt_pkg::ADDR_PORT_B_DIRECTION, 8'h02);
		wr(cpt_pkg::ADDR_PORT_B_SPECIAL_FUNCTION, 8'h02);
		`CHK("pin_oe", 1'b1, pin_oe_o)
		wr(cpt_pkg::ADDR_COUNT0, 8'h03);
		rd(cpt_pkg::ADDR_COUNT0, 8'h03);
		t = $realtime;
		wr(cpt_pkg::ADDR_CTRL, 8'h01);
		waitreq(0);
		`CHK("start", 1'b1, (tlast - t) > 240.0)
		rd(cpt_pkg::ADDR_CTRL, 8'h00);
		rd(cpt_pkg::ADDR_COUNT0, 8'h00);
		`CHK("pin", 1'b1, pin_o)
		wr(cpt_pkg::ADDR_LORL1, 8'h02);
		wr(cpt_pkg::ADDR_CTRL, 8'h22);
		waitreq(1);
		wr(cpt_pkg::ADDR_COUNT1, 8'h07);
		gap(1, 1, 64);
		wr(cpt_pkg::ADDR_LORL1, 8'h05);
		gap(1, 1, 24);
		gap(1, 1, 48);
		rd(cpt_pkg::ADDR_CTRL, 8'h22);
		wr(cpt_pkg::ADDR_CTRL, 8'h00);
		wr(cpt_pkg::ADDR_LORL2, 8'h03);
		wr(cpt_pkg::ADDR_LORL3, 8'h00);
		wr(cpt_pkg::ADDR_COUNT2, 8'h00);
		wr(cpt_pkg::ADDR_COUNT3, 8'h01);
		wr(cpt_pkg::ADDR_CTRL, 8'h04);
		repeat (20) @(posedge clock_i);
		rd(cpt_pkg::ADDR_COUNT3, 8'h00);
		`CHK("req2", 1'b0, req_o[2])
		waitreq(2);
		rd(cpt_pkg::ADDR_CTRL, 8'h04);
		gap(2, 2, 32);
		// Ticks fall seven clocks after a request shows, so these writes meet a tick
		repeat (5) @(posedge clock_i);
		wr(cpt_pkg::ADDR_COUNT2, 8'h10);
		rd(cpt_pkg::ADDR_COUNT2, 8'h10);
		wr(cpt_pkg::ADDR_CTRL, 8'h05);
		repeat (2) @(posedge clock_i);
		wr(cpt_pkg::ADDR_CTRL, 8'h05);
		rd(cpt_pkg::ADDR_CTRL, 8'h04);
		wr(cpt_pkg::ADDR_LORL0, 8'h01);
		wr(cpt_pkg::ADDR_REQ, 8'h01);
		wr(cpt_pkg::ADDR_CTRL, 8'h11);
		waitreq(0);
		gap(0, 0, 16);
		rd(cpt_pkg::ADDR_CTRL, 8'h11);
		wr(cpt_pkg::ADDR_CTRL, 8'h00);
		wr(cpt_pkg::ADDR_REQ, 8'h0F);
		wr(cpt_pkg::ADDR_LORL0, 8'h01);
		wr(cpt_pkg::ADDR_LORL1, 8'h00);
		wr(cpt_pkg::ADDR_HIRL0, 8'h02);
		wr(cpt_pkg::ADDR_HIRL1, 8'h00);
		wr(cpt_pkg::ADDR_COUNT0, 8'h01);
		wr(cpt_pkg::ADDR_COUNT1, 8'h00);
		wr(cpt_pkg::ADDR_CTRL, 8'h41);
		waitreq(0);
		`CHK("req1", 1'b0, req_o[1])
		gap(0, 0, 16);
		wr(cpt_pkg::ADDR_CTRL, 8'h00);
		wr(cpt_pkg::ADDR_REQ, 8'h0F);
		wr(cpt_pkg::ADDR_COUNT0, 8'h02);
		wr(cpt_pkg::ADDR_COUNT1, 8'h00);
		wr(cpt_pkg::ADDR_CTRL, 8'hC1);
		waitreq(1);
		`CHK("req0", 1'b0, req_o[0])
		gap(1, 0, 16);
		gap(0, 1, 24);
		`CHK("pin", 1'b1, pin_o)
		report_and_stop();
	end
endmodule : cascadable_timers_with_pwm_tb

// ===== verif/cpt_timers_assertions.sv
/*
 * Port checker for cpt_timers.
 * Assumes the register map and control layout of cpt_pkg.
 */
`timescale 1ns/10ps
module cpt_timers_checker (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [3:0] req_o,
	input wire logic timer_out_pin_o,
	input wire logic timer_out_pin_oe_o
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	logic [2:0] phase;
	logic [2:0] req_phase;
	logic seen;
	logic pin_fn;
	logic [3:0] prev_req;
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			phase <= 3'h0;
			req_phase <= 3'h0;
			seen <= 1'b0;
			prev_req <= 4'h0;
		end else begin
			phase <= phase + 3'h1;
			prev_req <= req_o;
			if (|(req_o & ~prev_req) && !seen) begin
				seen <= 1'b1;
				req_phase <= phase;
			end
		end
	end
	// Pin only follows the toggle flop while its special function is on
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			pin_fn <= 1'b0;
		end else if (wr_i && addr_i == cpt_pkg::ADDR_PORT_B_SPECIAL_FUNCTION) begin
			pin_fn <= wdata_i[1];
		end
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	sequence s_clear_write;
		wr_i && addr_i == cpt_pkg::ADDR_REQ;
	endsequence
	a_reset_quiet: assert property (disable iff (1'b0) !nrst_i |=> req_o == 4'h0 && rdata_o == 8'h00)
		else $error("outputs not quiet after reset");
	a_rdata_idle: assert property (rdata_o != 8'h00 |-> $past(rd_i))
		else $error("read data without read");
	a_unmapped_zero: assert property (rd_i && addr_i == 8'hC0 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_odd_req_never: assert property (req_o[3] == 1'b0)
		else $error("odd cascade request raised");
	a_dir_follows: assert property (wr_i && addr_i == cpt_pkg::ADDR_PORT_B_DIRECTION
		|-> ##2 timer_out_pin_oe_o == $past(wdata_i[1], 2))
		else $error("pin enable does not follow direction");
	a_clear_done: assert property (s_clear_write |-> ##2 (req_o & $past(wdata_i[3:0], 2)) == 4'h0)
		else $error("request not cleared");
	a_req_held: assert property (|(prev_req & ~req_o) |-> $past(wr_i, 2) && $past(addr_i, 2) == cpt_pkg::ADDR_REQ)
		else $error("request dropped without clear");
	a_pin_toggle: assert property ($rose(req_o[0]) && pin_fn |-> ##1 timer_out_pin_o != $past(timer_out_pin_o, 2))
		else $error("pin did not toggle");
	a_tick_phase: assert property (|(req_o & ~prev_req) && seen |-> phase == req_phase)
		else $error("request off the tick grid");
endmodule : cpt_timers_checker
bind cpt_timers cpt_timers_checker u_chk (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .req_o(req_o),
	.timer_out_pin_o(timer_out_pin_o), .timer_out_pin_oe_o(timer_out_pin_oe_o));
